// >>> src/microcode_step_and_match_control.sv
// Console that runs, stops, steps and matches a microprogrammed processor.
// Assumes the back panel samples the outputs on REF_CLK, and an AHB-Lite
// master with single word transfers.
//
// Behaviour
// RULE1: Run plus start lets clock run.
// RULE2: Clearing run stops the processor clock.
// RULE3: Each step while stopped gives one clock.
// RULE4: Opcode 5d plus step loads upper master.
// RULE5: Opcode 5e step loads lower, copies upper.
// RULE6: Next step fetches at the loaded address.
// RULE7: Halt on match stops after next fetch.
// RULE8: Freeze on match inhibits address increment.
// RULE9: Clear freeze, or clear halt then start.
// RULE10: Operator avoids load-lower or branch match addresses.
// RULE11: Three sense levels are static outputs.
// RULE12: Substitute clock stays within ten percent.
// RULE13: Initialize stops clock and clears address.
// RULE14: Twelve low switch bits match address.
// RULE15: Inject copies word, ignored while running.
// RULE16: Requests debounced, one press one action.
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none
module microcode_step_and_match_control
   import step_match_pkg::*;
(
   input  wire logic                 REF_CLK,
   input  wire logic                 RST,
   input  wire logic                 HSEL,
   input  wire logic [31:0]          HADDR,
   input  wire logic [1:0]           HTRANS,
   input  wire logic                 HWRITE,
   input  wire logic [2:0]           HSIZE,
   input  wire logic [31:0]          HWDATA,
   input  wire logic                 HREADY,
   output logic      [31:0]          HRDATA,
   output logic                      HREADYOUT,
   output logic                      HRESP,
   input  wire logic [UADDR_W-1:0]   MICRO_ADDR,
   input  wire logic [15:0]          MICRO_DATA,
   output logic                      PROC_CLOCK_EN,
   output logic                      SUBST_CLOCK,
   output logic                      INJECT_STROBE,
   output logic      [15:0]          INJECT_WORD,
   output logic                      FREEZE_INCREMENT,
   output logic                      INITIALIZE,
   output logic      [2:0]           SENSE,
   output logic                      MATCH,
   output logic      [UADDR_W-1:0]   UADDR_SHADOW,
   output logic                      IRQ
);

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic [31:0]        ctrl;
   logic [15:0]        switch_word;
   logic [EV_W-1:0]    status;
   logic [EV_W-1:0]    mask;
   logic               dp_write;
   logic               dp_read;
   logic [7:0]         dp_addr;
   logic               wr_ctrl;
   logic               wr_switch;
   logic               wr_mask;
   logic               wr_cmd;
   logic               rd_status;
   console_mode_t      mode;

   // The address phase is kept for the data phase; idle cycles clear the
   // strobes so that a stale write is never applied a second time.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         dp_write <= 1'b0;
         dp_read  <= 1'b0;
         dp_addr  <= 8'h00;
      end else if (HREADY) begin
         dp_write <= HSEL && HTRANS == HTRANS_NONSEQ && HWRITE;
         dp_read  <= HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE;
         dp_addr  <= HADDR[7:0];
      end else begin
         dp_write <= 1'b0;
         dp_read  <= 1'b0;
      end
   end

   // The slave never stalls, so every transfer completes in one cycle.
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   assign wr_ctrl   = dp_write && dp_addr == CTRL_OFS;
   assign wr_switch = dp_write && dp_addr == SWITCH_OFS;
   assign wr_mask   = dp_write && dp_addr == MASK_OFS;
   assign wr_cmd    = dp_write && dp_addr == CMD_OFS;
   assign rd_status = dp_read && dp_addr == STATUS_OFS;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ctrl <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= HWDATA;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         switch_word <= 16'h0000;
      end else if (wr_switch) begin
         switch_word <= HWDATA[15:0];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         mask <= '0;
      end else if (wr_mask) begin
         mask <= HWDATA[EV_W-1:0];
      end
   end

   // Fields are picked one by one: bit 7 of the control word is a gap,
   // so a plain cast of the low bits would shift the rate field.
   always_comb begin
      mode                         = '0;
      mode.run                     = ctrl[CTRL_RUN];
      mode.halt_on_match           = ctrl[CTRL_HALT_MATCH];
      mode.freeze_on_match         = ctrl[CTRL_FREEZE];
      mode.substitute_clock_select = ctrl[CTRL_SUBST];
      mode.sense_halt_on_error     = ctrl[CTRL_SENSE_LO];
      mode.sense_repeat_one_set    = ctrl[CTRL_SENSE_LO+1];
      mode.sense_wait_each_set     = ctrl[CTRL_SENSE_LO+2];
      mode.substitute_clock_rate   = ctrl[CTRL_RATE_LO +: CTRL_RATE_W];
   end

   // ****************************************************************
   // Request debounce
   // ****************************************************************
   // A command write is a press; further presses are ignored until the
   // hold-off time has passed, so one press is one action.
   logic [3:0]      cmd_req;
   logic [3:0]      cmd_go;
   logic [DB_W-1:0] holdoff [4];

   assign cmd_req = wr_cmd ? HWDATA[3:0] : 4'h0;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_db
         assign cmd_go[g] = cmd_req[g] && holdoff[g] == '0;
         always_ff @(posedge REF_CLK) begin
            if (RST) begin
               holdoff[g] <= '0;
            end else if (cmd_go[g]) begin
               holdoff[g] <= DB_W'(DEBOUNCE_CYC); // RULE16
            end else if (holdoff[g] != '0) begin
               holdoff[g] <= holdoff[g] - 1'b1;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Address match
   // ****************************************************************
   logic match;
   logic halt_match;

   assign match = MICRO_ADDR == switch_word[UADDR_W-1:0]; // RULE14
   assign MATCH = match;
   assign halt_match = mode.halt_on_match && match;

   // The inhibit must reach the processor in the cycle of the match: a
   // registered copy would let one increment slip past the address.
   assign FREEZE_INCREMENT = mode.freeze_on_match && match; // RULE8 RULE9

   // ****************************************************************
   // Clock control
   // ****************************************************************
   logic       running;
   logic       step_pulse;
   logic       halt_armed;
   logic       stopped_by_halt;
   logic       fire;
   logic       halt_now;
   logic       clock_gate;

   // Halt on match lets the clock that executes the matched instruction
   // through, which also fetches the next one, and blocks every later
   // clock at once; the run flag itself drops two cycles afterwards.
   assign fire     = PROC_CLOCK_EN || SUBST_CLOCK;
   assign halt_now = running && halt_match && fire;

   always_ff @(posedge REF_CLK) begin
      if (RST || cmd_go[CMD_INIT]) begin
         halt_armed <= 1'b0;
      end else begin
         halt_armed <= halt_now; // RULE7
      end
   end

   // Start is refused while a halt match stands: the operator clears the
   // halt mode first, or the clock would stop again at once.

   always_ff @(posedge REF_CLK) begin
      if (RST || cmd_go[CMD_INIT]) begin
         running <= 1'b0; // RULE13
      end else if (!mode.run) begin
         running <= 1'b0; // RULE2
      end else if (halt_armed) begin
         running <= 1'b0; // RULE7
      end else if (cmd_go[CMD_START] && !halt_match) begin
         running <= 1'b1; // RULE1 RULE9
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         stopped_by_halt <= 1'b0;
      end else if (halt_armed) begin
         stopped_by_halt <= 1'b1;
      end else if (running) begin
         stopped_by_halt <= 1'b0;
      end
   end

   // One step gives exactly one clock; ignored while running.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         step_pulse <= 1'b0;
      end else begin
         step_pulse <= cmd_go[CMD_STEP] && !running; // RULE3 RULE16
      end
   end

   // Substitute clock: a rate divider replaces the processor clock.
   logic [CTRL_RATE_W-1:0] rate_cnt;
   logic                   rate_tick;

   // The divider restarts from zero whenever the substitute clock is
   // deselected, so the first tick comes soon after it is chosen.
   assign rate_tick = rate_cnt == '0;

   always_ff @(posedge REF_CLK) begin
      if (RST || !mode.substitute_clock_select) begin
         rate_cnt <= '0;
      end else if (rate_tick) begin
         rate_cnt <= mode.substitute_clock_rate;
      end else begin
         rate_cnt <= rate_cnt - 1'b1;
      end
   end

   // Waiting for the run flag to drop would let two more clocks reach
   // the processor after the match, and an initialize must not meet a
   // clock in the same cycle.
   assign clock_gate = running && !halt_now && !halt_armed &&
                       !cmd_go[CMD_INIT]; // RULE7 RULE13

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         PROC_CLOCK_EN <= 1'b0;
         SUBST_CLOCK   <= 1'b0;
      end else begin
         PROC_CLOCK_EN <= step_pulse ||
            (clock_gate && !mode.substitute_clock_select); // RULE1 RULE3
         SUBST_CLOCK   <= step_pulse ||
            (clock_gate && mode.substitute_clock_select && rate_tick);
      end
   end

   // ****************************************************************
   // Injection and processor levels
   // ****************************************************************
   // The injected opcode 5d or 5e is executed by the processor on the
   // next step, loading the upper master or the lower and upper slave.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         INJECT_STROBE <= 1'b0;
         INJECT_WORD   <= 16'h0000;
      end else begin
         INJECT_STROBE <= cmd_go[CMD_INJECT] && !running; // RULE15
         if (cmd_go[CMD_INJECT] && !running) begin
            INJECT_WORD <= switch_word; // RULE4 RULE5
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         INITIALIZE       <= 1'b0;
         SENSE            <= 3'b000;
      end else begin
         INITIALIZE       <= cmd_go[CMD_INIT]; // RULE13
         SENSE <= {mode.sense_wait_each_set, mode.sense_repeat_one_set,
                   mode.sense_halt_on_error}; // RULE11
      end
   end

   // Shadow of the address the processor holds when a step is taken, before the step clock.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         UADDR_SHADOW <= '0;
      end else if (step_pulse) begin
         UADDR_SHADOW <= MICRO_ADDR; // RULE6
      end
   end

   // ****************************************************************
   // Interrupts and read data
   // ****************************************************************
   logic [EV_W-1:0] events;

   assign events = {step_pulse, halt_armed, match && !halt_armed};

   // A read clears the status, but an event in the same cycle survives.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         status <= '0;
      end else begin
         status <= (rd_status ? '0 : status) | events;
      end
   end

   // The interrupt is a level that follows status and mask directly.
   assign IRQ = |(status & mask);

   // Read data is combinational from the data-phase address, so a read
   // needs no wait state.
   always_comb begin
      unique case (dp_addr)
         CTRL_OFS:   HRDATA = ctrl;
         SWITCH_OFS: HRDATA = {16'h0000, switch_word};
         STATUS_OFS: HRDATA = {{(32-EV_W){1'b0}}, status};
         MASK_OFS:   HRDATA = {{(32-EV_W){1'b0}}, mask};
         ADDR_OFS:   HRDATA = {13'h0000, stopped_by_halt, running,
                               MICRO_DATA[UPPER_W-1:0],
                               match, MICRO_ADDR};
         default:    HRDATA = 32'h0000_0000;
      endcase
   end

   logic unused;
   assign unused = ^{HSIZE, ctrl[31:CTRL_RATE_LO+CTRL_RATE_W],
                     ctrl[CTRL_RATE_LO-1], MICRO_DATA[15:UPPER_W]};

endmodule
`default_nettype wire

// >>> src/step_match_pkg.sv
// Package of constants, register offsets and bundled types for the
// microcode step and match console.
// Assumes a 32-bit AHB-Lite slave interface and a single 250 MHz clock.
`default_nettype none
package step_match_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0]  CTRL_OFS    = 8'h00;
   localparam logic [7:0]  SWITCH_OFS  = 8'h04;
   localparam logic [7:0]  STATUS_OFS  = 8'h08;
   localparam logic [7:0]  MASK_OFS    = 8'h0c;
   localparam logic [7:0]  ADDR_OFS    = 8'h10;
   localparam logic [7:0]  CMD_OFS     = 8'h14;

   // Control fields.
   localparam int CTRL_RUN        = 0;
   localparam int CTRL_HALT_MATCH = 1;
   localparam int CTRL_FREEZE     = 2;
   localparam int CTRL_SUBST      = 3;
   localparam int CTRL_SENSE_LO   = 4;
   localparam int CTRL_RATE_LO    = 8;
   localparam int CTRL_RATE_W     = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Command bits, write-one pulses.
   localparam int CMD_START  = 0;
   localparam int CMD_STEP   = 1;
   localparam int CMD_INJECT = 2;
   localparam int CMD_INIT   = 3;

   // Status event bits.
   localparam int EV_MATCH = 0;
   localparam int EV_HALT  = 1;
   localparam int EV_STEP  = 2;
   localparam int EV_W     = 3;

   // Microinstruction layout.
   localparam logic [7:0] OP_LOAD_UPPER = 8'h5d;
   localparam logic [7:0] OP_LOAD_LOWER = 8'h5e;
   localparam int UADDR_W = 12;
   localparam int UPPER_W = 4;

   // Debounce of a request: 1 us least.
   localparam int DEBOUNCE_NS  = 1000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int DEBOUNCE_CYC =
      (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DB_W = 8;

   typedef enum logic [1:0] {
      HTRANS_IDLE   = 2'b00,
      HTRANS_BUSY   = 2'b01,
      HTRANS_NONSEQ = 2'b10,
      HTRANS_SEQ    = 2'b11
   } htrans_t;

   // Mode switches of the console.
   typedef struct packed {
      logic [CTRL_RATE_W-1:0] substitute_clock_rate;
      logic                   sense_wait_each_set;
      logic                   sense_repeat_one_set;
      logic                   sense_halt_on_error;
      logic                   substitute_clock_select;
      logic                   freeze_on_match;
      logic                   halt_on_match;
      logic                   run;
   } console_mode_t;

   // Processor-facing control levels and pulses.
   typedef struct packed {
      logic        clock_pulse;
      logic        freeze_increment;
      logic        initialize;
      logic        inject_strobe;
      logic [15:0] inject_word;
      logic [2:0]  sense;
   } panel_out_t;

endpackage
`default_nettype wire

// >>> verification/micro_proc_model.sv
// Behavioural model of the microprogrammed processor on the back panel.
// Assumes every fetched word is a no-op, so only injected words load.
`default_nettype none
module micro_proc_model
   import step_match_pkg::*;
(
   input  wire logic               REF_CLK,
   input  wire logic               PROC_CLOCK_EN,
   input  wire logic               INJECT_STROBE,
   input  wire logic [15:0]        INJECT_WORD,
   input  wire logic               FREEZE_INCREMENT,
   input  wire logic               INITIALIZE,
   output logic      [UADDR_W-1:0] MICRO_ADDR,
   output logic      [15:0]        MICRO_DATA
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // Sequencer
   // ********
   logic [UPPER_W-1:0] upper_master;
   initial begin
      MICRO_ADDR = '0;
      MICRO_DATA = '0;
      upper_master = '0;
   end
   always @(posedge REF_CLK) begin
      if (INITIALIZE) begin
         MICRO_ADDR <= '0;
         upper_master <= '0;
      end else if (INJECT_STROBE) begin
         MICRO_DATA <= INJECT_WORD;
      end else if (PROC_CLOCK_EN) begin
         MICRO_DATA <= 16'h0000;
         if (MICRO_DATA[7:0] == OP_LOAD_UPPER)
            upper_master <= MICRO_DATA[11:8];
         if (MICRO_DATA[7:0] == OP_LOAD_LOWER)
            MICRO_ADDR <= {upper_master, MICRO_DATA[15:8]};
         else if (!FREEZE_INCREMENT)
            MICRO_ADDR <= MICRO_ADDR + 12'h001;
      end
   end
endmodule
`default_nettype wire

// >>> verification/microcode_step_and_match_control_tb_top.sv
// Self-checking bench for the step and match console.
// Assumes zero wait state bus slave and a 250-cycle request holdoff.
`default_nettype none
module microcode_step_and_match_control_tb_top import step_match_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0]  a;
      logic [31:0] w;
      logic [31:0] r;
      logic [2:0]  s;
   } row_t;
   row_t               rows[6] = '{
      '{CTRL_OFS, 32'h70, 32'h70, 3'h7}, '{CTRL_OFS, 32'h10, 32'h10, 3'h1},
      '{CTRL_OFS, 32'h40, 32'h40, 3'h4}, '{CTRL_OFS, 32'h0, 32'h0, 3'h0},
      '{MASK_OFS, 32'h7, 32'h7, 3'h0}, '{8'h1c, 32'hffff_ffff, 32'h0, 3'h0}};
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic               hwrite = 1'b0;
   logic [1:0]         htrans = HTRANS_IDLE;
   logic [31:0]        haddr = 32'h0;
   logic [31:0]        hwdata = 32'h0;
   logic [31:0]        hrdata, q;
   logic               hready, hresp, clk_en, inj, freeze, init, match, irq;
   logic               subst;
   logic [15:0]        inj_word, mdata;
   logic [UADDR_W-1:0] maddr, shadow;
   logic [2:0]         sense;
   int                 errors = 0, checks = 0, pulses, strobes, ticks;

   microcode_step_and_match_control DUT (.REF_CLK(clk), .RST(rst),
      .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .MICRO_ADDR(maddr),
      .MICRO_DATA(mdata), .PROC_CLOCK_EN(clk_en), .SUBST_CLOCK(subst),
      .INJECT_STROBE(inj), .INJECT_WORD(inj_word),
      .FREEZE_INCREMENT(freeze), .INITIALIZE(init), .SENSE(sense),
      .MATCH(match), .UADDR_SHADOW(shadow), .IRQ(irq));
   micro_proc_model u_proc (.REF_CLK(clk), .PROC_CLOCK_EN(clk_en | subst),
      .INJECT_STROBE(inj), .INJECT_WORD(inj_word),
      .FREEZE_INCREMENT(freeze), .INITIALIZE(init), .MICRO_ADDR(maddr),
      .MICRO_DATA(mdata));

   // ********
   // Tasks
   // ********
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= HTRANS_IDLE;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask
   // Waits out the holdoff so the next press of the same button counts.
   task automatic cmd(input int b);
      wr(CMD_OFS, 32'h1 << b);
      pulses = 0;
      strobes = 0;
      ticks = 0;
      repeat (260) begin
         @(posedge clk);
         pulses += int'(clk_en === 1'b1);
         ticks += int'(subst === 1'b1);
         strobes += int'(inj === 1'b1);
      end
   endtask
   task automatic cmp(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial forever #2 clk = ~clk;
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      wrap_up();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      cmp("clock_en", 32'h0, 32'(clk_en));
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, q);
         cmp("readback", rows[i].r, q);
         cmp("sense", 32'(rows[i].s), 32'(sense));
      end
      $display("test registers done");
      wr(SWITCH_OFS, 32'h035d);
      cmd(CMD_INJECT);
      cmp("inject_word", 32'h035d, 32'(inj_word));
      cmd(CMD_STEP);
      cmp("step_pulses", 32'h1, 32'(pulses));
      wr(SWITCH_OFS, 32'h475e);
      cmd(CMD_INJECT);
      cmd(CMD_STEP);
      cmp("loaded_addr", 32'h347, 32'(maddr));
      cmd(CMD_STEP);
      cmp("fetched_addr", 32'h348, 32'(maddr));
      cmp("shadow", 32'h347, 32'(shadow));
      $display("test address load done");
      wr(SWITCH_OFS, 32'h0350);
      wr(CTRL_OFS, 32'h5);
      cmd(CMD_START);
      cmp("running", 32'h1, 32'(pulses > 200));
      cmp("frozen_addr", 32'h350, 32'(maddr));
      cmp("match", 32'h1, 32'(match));
      cmd(CMD_INJECT);
      cmp("inject_running", 32'h0, 32'(strobes));
      wr(CTRL_OFS, 32'h1);
      repeat (8) @(posedge clk);
      cmp("resumed", 32'h1, 32'(maddr != 12'h350));
      wr(CTRL_OFS, 32'h0);
      cmd(CMD_STEP);
      cmp("stopped_step", 32'h1, 32'(pulses));
      $display("test run and freeze done");
      cmd(CMD_INIT);
      cmp("init_addr", 32'h0, 32'(maddr));
      wr(SWITCH_OFS, 32'h0040);
      rd(STATUS_OFS, q);
      wr(CTRL_OFS, 32'h3);
      cmd(CMD_START);
      cmp("halt_addr", 32'h41, 32'(maddr));
      cmp("irq_set", 32'h1, 32'(irq));
      rd(STATUS_OFS, q);
      cmp("halt_event", 32'h2, q & 32'h2);
      @(posedge clk);
      cmp("irq_clear", 32'h0, 32'(irq));
      wr(CTRL_OFS, 32'h1);
      cmd(CMD_START);
      cmp("restart", 32'h1, 32'(pulses > 200));
      wr(CTRL_OFS, 32'h0);
      $display("test halt done");
      wr(CTRL_OFS, 32'h309);
      cmd(CMD_START);
      cmp("subst_ticks", 32'd65, 32'(ticks));
      cmp("subst_main_off", 32'h0, 32'(pulses));
      wr(CTRL_OFS, 32'h0);
      wr(CMD_OFS, 32'h1 << CMD_STEP);
      cmd(CMD_STEP);
      cmp("double_step", 32'h0, 32'(pulses));
      $display("test substitute clock and debounce done");
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      cmp("reset_clock_en", 32'h0, 32'(clk_en));
      rd(CTRL_OFS, q);
      cmp("reset_ctrl", CTRL_RESET, q);
      cmp("reset_irq", 32'h0, 32'(irq));
      $display("test reset done");
      wrap_up();
   end
endmodule
`default_nettype wire

// >>> verification/step_match_props.sv
// Port checker for the step and match console.
// Assumes one clock domain and RST as a synchronous reset.
`default_nettype none
module step_match_props
   import step_match_pkg::*;
(
   input wire logic               REF_CLK,
   input wire logic               RST,
   input wire logic               HREADYOUT,
   input wire logic               HRESP,
   input wire logic [UADDR_W-1:0] MICRO_ADDR,
   input wire logic               PROC_CLOCK_EN,
   input wire logic               INJECT_STROBE,
   input wire logic               FREEZE_INCREMENT,
   input wire logic               INITIALIZE,
   input wire logic               MATCH,
   input wire logic [UADDR_W-1:0] UADDR_SHADOW
);
   // ********
   // Checks
   // ********
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   a_bus_never_waits: assert property (HREADYOUT && !HRESP)
      else $error("bus slave stalled or signalled an error");
   a_freeze_needs_match: assert property (
      FREEZE_INCREMENT |-> MATCH)
      else $error("address freeze without a match");
   a_inject_one_press: assert property (
      INJECT_STROBE |=> !INJECT_STROBE [*8])
      else $error("inject strobe repeated within holdoff");
   a_init_one_press: assert property (
      $rose(INITIALIZE) |=> !INITIALIZE ##1 !INITIALIZE [*7])
      else $error("initialize pulse longer or repeated");
   a_init_stops_clock: assert property (
      INITIALIZE |-> !PROC_CLOCK_EN)
      else $error("processor clock runs during initialize");
   a_inject_when_stopped: assert property (
      INJECT_STROBE |-> !(PROC_CLOCK_EN && $past(PROC_CLOCK_EN)))
      else $error("inject strobe while clock running");
   a_shadow_on_clock: assert property (
      $changed(UADDR_SHADOW) && !$past(RST) |->
         PROC_CLOCK_EN && UADDR_SHADOW == $past(MICRO_ADDR))
      else $error("shadow address changed without a clock");
   a_reset_quiet: assert property ($past(RST) |->
      !PROC_CLOCK_EN && !INJECT_STROBE && !INITIALIZE && !FREEZE_INCREMENT)
      else $error("panel outputs active just after reset");
endmodule

bind microcode_step_and_match_control step_match_props u_props (
   .REF_CLK(REF_CLK), .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .MICRO_ADDR(MICRO_ADDR), .PROC_CLOCK_EN(PROC_CLOCK_EN),
   .INJECT_STROBE(INJECT_STROBE), .FREEZE_INCREMENT(FREEZE_INCREMENT),
   .INITIALIZE(INITIALIZE), .MATCH(MATCH), .UADDR_SHADOW(UADDR_SHADOW));
`default_nettype wire
